// >>> design/item_store.sv
module item_store (
	// clock
	input wire logic clk,
	// access
	item_store_if.mem port
);
	// contents need no reset: pointers define what is valid
	sample_fifo_pkg::item_t mem_r [0:127];

	always_ff @(posedge clk) begin
		if (port.wr_en) begin
			mem_r[port.wr_addr] <= port.wr_data;
		end
	end

	assign port.rd_data = mem_r[port.rd_addr];
endmodule

// >>> design/item_store_if.sv
interface item_store_if;
	logic                  wr_en;
	sample_fifo_pkg::index_t wr_addr;
	sample_fifo_pkg::item_t  wr_data;
	sample_fifo_pkg::index_t rd_addr;
	sample_fifo_pkg::item_t  rd_data;
	modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// >>> design/optical_sample_fifo_control.sv
`include "sample_fifo_defines.svh"

module optical_sample_fifo_control (
	// clock and resets
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        soft_reset,
	// conversion results
	input  wire logic        sample_valid,
	input  wire logic [4:0]  sample_tag,
	input  wire logic [18:0] sample_value,
	// register access from the serial front end
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	// interrupt pin
	output logic             int_n
);
	item_store_if st ();

	item_store u_store (
		.clk  (clk),
		.port (st.mem)
	);

	////////////////////////////////////////////////////////////////////////////
	logic                          rst;
	sample_fifo_pkg::index_t       push_index_r, push_index_nxt;
	sample_fifo_pkg::index_t       pop_index_r, pop_index_nxt;
	logic [7:0]                    pend_r, pend_nxt;
	logic [6:0]                    lost_item_count_r, lost_item_count_nxt;
	logic [6:0]                    wm_r, wm_nxt;
	logic [7:0]                    cfg_r, cfg_nxt;
	logic [7:0]                    ien_r, ien_nxt;
	logic                          flush_r, flush_nxt;
	logic                          af_r, af_nxt;
	logic                          dr_r, dr_nxt;
	logic                          cond_r, cond_nxt;
	sample_fifo_pkg::byte_phase_t  phase_r, phase_nxt;
	logic [2:0]                    ts_div_r, ts_div_nxt;
	logic                          ts_pend_r, ts_pend_nxt;
	logic [18:0]                   stamp_r, stamp_nxt;
	logic [7:0]                    rdata_r, rdata_nxt;
	logic                          item_valid, ts_push, pop, full, lost, overwrite;
	logic                          status_rd, data_rd, cfg_wr;
	logic [7:0]                    pend_after_pop, threshold, rd_mux;
	sample_fifo_pkg::item_t        item;

	logic overwrite_on_full, clear_flags_on_data_read;
	assign rst = !rst_n || soft_reset;
	assign overwrite_on_full        = cfg_r[`BIT_OVERWRITE];
	assign clear_flags_on_data_read = cfg_r[`BIT_STAT_CLR];

	function automatic logic [6:0] sat_inc(input logic [6:0] v);
		sat_inc = (v == `LOST_MAX) ? v : v + 7'h01;
	endfunction

	function automatic logic [7:0] pick_byte(input sample_fifo_pkg::item_t w,
	                                         input sample_fifo_pkg::byte_phase_t p);
		case (p)
			sample_fifo_pkg::BYTE_HI:  pick_byte = w[23:16]; // RQ19
			sample_fifo_pkg::BYTE_MID: pick_byte = w[15:8];
			sample_fifo_pkg::BYTE_LO:  pick_byte = w[7:0];
			default:                   pick_byte = 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	assign status_rd  = reg_rd && (reg_addr == `ADDR_INT_STATUS);
	assign data_rd    = reg_rd && (reg_addr == `ADDR_DATA_PORT);
	assign cfg_wr     = reg_wr && (reg_addr == `ADDR_BEHAVIOUR);
	// a sample always wins the slot; a pending stamp waits for an idle cycle
	assign ts_push    = ts_pend_r && !sample_valid && cfg_r[`BIT_TS_EN]; // RQ14
	assign item_valid = sample_valid || ts_push;
	assign item       = sample_valid ? {sample_tag, sample_value}
	                                 : {`TS_TAG_CODE, stamp_r}; // RQ1 RQ13
	assign pop        = data_rd && (phase_r == sample_fifo_pkg::BYTE_LO) && (pend_r != 8'h00); // RQ18
	assign pend_after_pop = pend_r - {7'h00, pop};
	assign full       = (pend_after_pop == `QUEUE_DEPTH);
	assign lost       = item_valid && full;
	assign overwrite  = lost && overwrite_on_full; // RQ5
	assign threshold  = `QUEUE_DEPTH - {1'b0, wm_r}; // RQ2

	assign st.wr_en   = item_valid && (!full || overwrite_on_full) && !flush_r; // RQ5 RQ6
	assign st.wr_addr = push_index_r;
	assign st.wr_data = item;
	assign st.rd_addr = pop_index_r;

	always_comb begin
		push_index_nxt      = push_index_r;
		pop_index_nxt       = pop_index_r;
		pend_nxt            = pend_after_pop; // RQ17
		lost_item_count_nxt = pop ? 7'h00 : lost_item_count_r; // RQ16
		phase_nxt           = phase_r;
		if (st.wr_en) begin
			push_index_nxt = push_index_r + 7'h01; // RQ15
		end
		if (pop || overwrite) begin
			pop_index_nxt = pop_index_r + 7'h01; // RQ18 RQ5
		end
		if (st.wr_en && !full) begin
			pend_nxt = pend_after_pop + 8'h01; // RQ17
		end
		if (lost) begin
			lost_item_count_nxt = sat_inc(lost_item_count_r); // RQ16 RQ6
		end
		if (data_rd) begin
			case (phase_r)
				sample_fifo_pkg::BYTE_HI:  phase_nxt = sample_fifo_pkg::BYTE_MID;
				sample_fifo_pkg::BYTE_MID: phase_nxt = sample_fifo_pkg::BYTE_LO;
				default:                   phase_nxt = sample_fifo_pkg::BYTE_HI;
			endcase
		end
		// host rewrite of the pop index lets an item be read again
		if (reg_wr && reg_addr == `ADDR_POP_INDEX) begin
			pop_index_nxt = reg_wdata[6:0];
			pend_nxt      = {1'b0, push_index_nxt - reg_wdata[6:0]}; // RQ20
			phase_nxt     = sample_fifo_pkg::BYTE_HI;
		end
		if (flush_r) begin
			push_index_nxt      = 7'h00; // RQ11
			pop_index_nxt       = 7'h00;
			pend_nxt            = 8'h00;
			lost_item_count_nxt = 7'h00;
			phase_nxt           = sample_fifo_pkg::BYTE_HI;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		wm_nxt      = wm_r;
		cfg_nxt     = cfg_r;
		ien_nxt     = ien_r;
		flush_nxt   = 1'b0; // RQ12
		ts_div_nxt  = ts_div_r;
		ts_pend_nxt = ts_pend_r && !ts_push && cfg_r[`BIT_TS_EN];
		stamp_nxt   = stamp_r;
		if (reg_wr && reg_addr == `ADDR_WATERMARK) begin
			wm_nxt = reg_wdata[6:0];
		end
		if (reg_wr && reg_addr == `ADDR_INT_ENABLE) begin
			ien_nxt = reg_wdata & 8'hc0;
		end
		if (cfg_wr) begin
			cfg_nxt   = reg_wdata & 8'h2e;
			flush_nxt = reg_wdata[`BIT_FLUSH];
		end
		if (sample_valid) begin
			stamp_nxt  = stamp_r + 19'h00001;
			ts_div_nxt = ts_div_r + 3'h1;
			if (cfg_r[`BIT_TS_EN] && ts_div_r == `TS_PERIOD_LAST) begin
				ts_pend_nxt = 1'b1; // RQ13
			end
		end
		if (flush_r) begin
			ts_div_nxt = 3'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	logic af_set, flag_clr;
	assign cond_nxt = (pend_nxt >= threshold);
	assign flag_clr = status_rd || (clear_flags_on_data_read && data_rd); // RQ4 RQ9 RQ10
	assign af_set   = ien_r[`BIT_A_FULL] && cond_nxt &&
	                  (cfg_r[`BIT_A_FULL_TYPE] ? !cond_r : item_valid); // RQ7 RQ8 RQ3
	// a set arriving with a clear wins, so no event is lost
	assign af_nxt   = af_set || (af_r && !flag_clr);
	assign dr_nxt   = (ien_r[`BIT_DATA_RDY] && item_valid) || (dr_r && !flag_clr);

	always_comb begin
		case (reg_addr)
			`ADDR_INT_STATUS: rd_mux = {af_r, dr_r, 6'h00};
			`ADDR_INT_ENABLE: rd_mux = ien_r;
			`ADDR_PUSH_INDEX: rd_mux = {1'b0, push_index_r};
			`ADDR_POP_INDEX:  rd_mux = {1'b0, pop_index_r};
			`ADDR_LOST_COUNT: rd_mux = {1'b0, lost_item_count_r};
			`ADDR_PEND_COUNT: rd_mux = pend_r;
			`ADDR_DATA_PORT:  rd_mux = pick_byte(st.rd_data, phase_r);
			`ADDR_WATERMARK:  rd_mux = {1'b0, wm_r};
			`ADDR_BEHAVIOUR:  rd_mux = cfg_r | {3'h0, flush_r, 4'h0};
			default:          rd_mux = 8'h00;
		endcase
		rdata_nxt = reg_rd ? rd_mux : rdata_r;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			push_index_r      <= 7'h00;
			pop_index_r       <= 7'h00;
			pend_r            <= 8'h00;
			lost_item_count_r <= 7'h00;
			wm_r              <= 7'h00;
			cfg_r             <= `RST_BYTE;
			ien_r             <= `RST_BYTE;
			flush_r           <= 1'b0;
			af_r              <= 1'b0;
			dr_r              <= 1'b0;
			cond_r            <= 1'b0;
			phase_r           <= sample_fifo_pkg::BYTE_HI;
			ts_div_r          <= 3'h0;
			ts_pend_r         <= 1'b0;
			stamp_r           <= 19'h00000;
			rdata_r           <= 8'h00;
		end else begin
			push_index_r      <= push_index_nxt;
			pop_index_r       <= pop_index_nxt;
			pend_r            <= pend_nxt;
			lost_item_count_r <= lost_item_count_nxt;
			wm_r              <= wm_nxt;
			cfg_r             <= cfg_nxt;
			ien_r             <= ien_nxt;
			flush_r           <= flush_nxt;
			af_r              <= af_nxt;
			dr_r              <= dr_nxt;
			cond_r            <= cond_nxt;
			phase_r           <= phase_nxt;
			ts_div_r          <= ts_div_nxt;
			ts_pend_r         <= ts_pend_nxt;
			stamp_r           <= stamp_nxt;
			rdata_r           <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign int_n     = !(af_r || dr_r); // RQ3

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence flush_req;
		cfg_wr && reg_wdata[`BIT_FLUSH] && !soft_reset;
	endsequence
	sequence flush_done;
		flush_r ##1 (push_index_r == 7'h00 && pop_index_r == 7'h00 && pend_r == 8'h00 &&
		             lost_item_count_r == 7'h00);
	endsequence

	flush_clears_a: assert property (flush_req |=> flush_done) // RQ11
		else $error("flush did not zero the queue state");
	flush_self_a: assert property (flush_r && !cfg_wr |=> !flush_r) // RQ12
		else $error("flush bit did not clear itself");
	push_wrap_a: assert property (st.wr_en && !flush_r && push_index_r == 7'h7f
	                              |=> push_index_r == 7'h00) // RQ15
		else $error("push index did not wrap");
	lost_sat_a: assert property (lost_item_count_r == `LOST_MAX && !pop && !flush_r
	                             |=> lost_item_count_r == `LOST_MAX) // RQ16
		else $error("lost count left saturation");
	pop_lost_a: assert property (pop && !flush_r |=> lost_item_count_r == 7'h00) // RQ16
		else $error("lost count not zeroed on pop");
	drop_keep_a: assert property (lost && !overwrite_on_full && !flush_r && !reg_wr
	                              |=> $stable(push_index_r) && $stable(pop_index_r) && pend_r == 8'h80) // RQ6
		else $error("dropped item changed the queue");
	count_diff_a: assert property (pend_r[6:0] == push_index_r - pop_index_r) // RQ20
		else $error("pending count disagrees with indices");
	pop_step_a: assert property (pop && !overwrite && !flush_r && !reg_wr
	                             |=> pop_index_r == $past(pop_index_r) + 7'h01) // RQ18
		else $error("pop index did not step after third byte");
	af_pin_a: assert property (af_r |-> !int_n) // RQ3
		else $error("almost-full not on interrupt pin");
	status_clr_a: assert property (status_rd && !af_set |=> !af_r) // RQ4
		else $error("status read did not clear almost-full");
	keep_flags_a: assert property (data_rd && !status_rd && !clear_flags_on_data_read && af_r
	                               |=> af_r) // RQ9
		else $error("data read cleared flag while clearing disabled");
	no_stamp_a: assert property (!cfg_r[`BIT_TS_EN] && st.wr_en |-> sample_valid) // RQ14
		else $error("stamp queued while disabled");
	af_level_a: assert property (ien_r[`BIT_A_FULL] && !cfg_r[`BIT_A_FULL_TYPE] && item_valid &&
	                             cond_nxt |=> af_r) // RQ7 RQ2
		else $error("almost-full not reasserted on new item");
	af_edge_a: assert property (cfg_r[`BIT_A_FULL_TYPE] && cond_r && cond_nxt && !af_r
	                            |=> !af_r) // RQ8
		else $error("almost-full reasserted without a new crossing");
endmodule

// >>> design/sample_fifo_defines.svh
// Overview of operation
// (RQ1) each item is 24 bits: 5-bit type code on top, 19-bit value below
// (RQ2) almost-full flag sets when item count reaches 128 minus watermark
// (RQ3) with its mask bit set, almost-full shows in status and on interrupt pin
// (RQ4) reading the interrupt status register clears the almost-full flag
// (RQ5) overwrite-on-full set: new items still enter a full queue, oldest lost
// (RQ6) overwrite-on-full clear: item arriving at full queue is dropped, queue untouched
// (RQ7) repeat select low: flag reasserts on every new item while condition holds
// (RQ8) repeat select high: flag asserts only when the condition newly arises
// (RQ9) clear-on-data-read low: data port reads leave both flags set
// (RQ10) clear-on-data-read high: data port read or status read clears both flags
// (RQ11) flush empties queue, zeroes push, pop, pending and lost counts
// (RQ12) flush bit clears itself once the flush is done
// (RQ13) time stamp enabled: a 19-bit stamp item is queued every 8 samples
// (RQ14) time stamp disabled: no stamp items are queued
// (RQ15) push index is 7 bits, one step per push, wraps 0x7f to 0x00
// (RQ16) lost count steps per lost item, saturates at 0x7f, zeroes on pop
// (RQ17) pending count rises on push and falls on each item the host reads
// (RQ18) host reads three bytes per item; pop index steps after the third
// (RQ19) item bytes leave most significant first, type code in first byte top
// (RQ20) queue holds 128 items; pending count equals push minus pop index
`ifndef SAMPLE_FIFO_DEFINES_SVH
`define SAMPLE_FIFO_DEFINES_SVH

`define ADDR_INT_STATUS   8'h00
`define ADDR_INT_ENABLE   8'h03
`define ADDR_PUSH_INDEX   8'h04
`define ADDR_POP_INDEX    8'h05
`define ADDR_LOST_COUNT   8'h06
`define ADDR_PEND_COUNT   8'h07
`define ADDR_DATA_PORT    8'h08
`define ADDR_WATERMARK    8'h09
`define ADDR_BEHAVIOUR    8'h0a

`define BIT_A_FULL        7
`define BIT_DATA_RDY      6
`define BIT_TS_EN         5
`define BIT_FLUSH         4
`define BIT_STAT_CLR      3
`define BIT_A_FULL_TYPE   2
`define BIT_OVERWRITE     1

`define QUEUE_DEPTH       8'h80
`define LOST_MAX          7'h7f
`define TS_PERIOD_LAST    3'h7
`define TS_TAG_CODE       5'h1e
`define RST_BYTE          8'h00

`endif

// >>> design/sample_fifo_pkg.sv
package sample_fifo_pkg;
	typedef logic [23:0] item_t;
	typedef logic [6:0]  index_t;
	typedef enum logic [2:0] {
		BYTE_HI  = 3'b001,
		BYTE_MID = 3'b010,
		BYTE_LO  = 3'b100
	} byte_phase_t;
endpackage

// >>> sim/host_model.sv
module host_model (
	// clock
	input  wire logic       clk,
	// register port toward the block
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end

	////////////////////////////////////////////////////////////////
	// idle lines carry the inverse of the last value, never a stale copy
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask

	// whole items only: three data port bytes, top byte first
	task automatic rd_item(output logic [23:0] it);
		logic [7:0] b;
		it = 24'h000000;
		repeat (3) begin
			rd(8'h08, b);
			it = {it[15:0], b};
		end
	endtask
endmodule

// >>> sim/tb_optical_sample_fifo_control.sv
module tb_optical_sample_fifo_control;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        soft_reset = 1'b0;
	logic        sample_valid = 1'b0;
	logic [4:0]  sample_tag = 5'h00;
	logic [18:0] sample_value = 19'h00000;
	logic [7:0]  reg_addr;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic        int_n;
	int          err_total = 0;
	int          checks = 0;

	always #2 clk = ~clk;

	host_model i_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	optical_sample_fifo_control i_dut (.clk(clk), .rst_n(rst_n), .soft_reset(soft_reset),
		.sample_valid(sample_valid), .sample_tag(sample_tag), .sample_value(sample_value),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .int_n(int_n));

	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		i_host.rd(a, d);
		chk($sformatf("reg %h", a), {16'h0000, d}, {16'h0000, exp});
	endtask

	// one spare cycle so the registered flags have landed
	task automatic ichk(input logic exp);
		@(negedge clk);
		chk("int_n", {23'h000000, int_n}, {23'h000000, exp});
	endtask

	task automatic push(input logic [4:0] t, input logic [18:0] v);
		@(negedge clk);
		sample_tag = t;
		sample_value = v;
		sample_valid = 1'b1;
		@(negedge clk);
		sample_valid = 1'b0;
		sample_tag = ~t;
		sample_value = ~v;
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		for (int a = 4; a < 11; a++) begin
			if (a != 8) rchk(8'(a), 8'h00);
		end
		ichk(1'b1);
		i_host.wr(8'h09, 8'h55);
		rchk(8'h09, 8'h55);
		@(negedge clk);
		soft_reset = 1'b1;
		@(negedge clk);
		soft_reset = 1'b0;
		rchk(8'h09, 8'h00);
		i_host.wr(8'h20, 8'hff);
		rchk(8'h20, 8'h00);
		i_host.wr(8'h04, 8'h33);
		rchk(8'h04, 8'h00);
	endtask

	task automatic t_format;
		logic [23:0] it;
		push(5'h03, 19'h45678);
		rchk(8'h04, 8'h01);
		rchk(8'h07, 8'h01);
		i_host.rd_item(it);
		chk("item", it, {5'h03, 19'h45678});
		rchk(8'h05, 8'h01);
		rchk(8'h07, 8'h00);
		// rewinding the pop index makes the item readable again
		i_host.wr(8'h05, 8'h00);
		rchk(8'h07, 8'h01);
		i_host.rd_item(it);
		chk("reread", it, {5'h03, 19'h45678});
	endtask

	task automatic t_full;
		logic [23:0] it;
		i_host.wr(8'h0a, 8'h10);
		for (int i = 0; i < 128; i++) push(5'h02, 19'(i));
		rchk(8'h04, 8'h00);
		rchk(8'h07, 8'h80);
		for (int i = 0; i < 128; i++) push(5'h05, 19'h00000);
		rchk(8'h04, 8'h00);
		rchk(8'h07, 8'h80);
		rchk(8'h06, 8'h7f);
		i_host.wr(8'h0a, 8'h02);
		push(5'h04, 19'h7ffff);
		rchk(8'h04, 8'h01);
		rchk(8'h07, 8'h80);
		i_host.rd_item(it);
		chk("oldest", it, {5'h02, 19'h00001});
		rchk(8'h06, 8'h00);
		rchk(8'h05, 8'h02);
		rchk(8'h07, 8'h7f);
		i_host.wr(8'h0a, 8'h12);
		rchk(8'h0a, 8'h02);
		for (int a = 4; a < 8; a++) rchk(8'(a), 8'h00);
	endtask

	task automatic t_afull;
		logic [7:0] d;
		i_host.wr(8'h09, 8'h7d);
		i_host.wr(8'h03, 8'h80);
		repeat (2) push(5'h01, 19'h00010);
		ichk(1'b1);
		push(5'h01, 19'h00011);
		ichk(1'b0);
		rchk(8'h00, 8'h80);
		ichk(1'b1);
		push(5'h01, 19'h00012);
		ichk(1'b0);
		i_host.rd(8'h08, d);
		ichk(1'b0);
		i_host.wr(8'h0a, 8'h0a);
		i_host.rd(8'h08, d);
		ichk(1'b1);
		// edge mode: a flush restarts the count below the mark
		i_host.wr(8'h0a, 8'h16);
		repeat (3) push(5'h01, 19'h00020);
		ichk(1'b0);
		rchk(8'h00, 8'h80);
		push(5'h01, 19'h00021);
		ichk(1'b1);
	endtask

	task automatic t_stamp;
		logic [23:0] it;
		i_host.wr(8'h0a, 8'h12);
		for (int i = 0; i < 8; i++) push(5'h01, 19'(i));
		rchk(8'h07, 8'h08);
		i_host.wr(8'h0a, 8'h32);
		for (int i = 0; i < 8; i++) push(5'h01, 19'(i));
		repeat (2) @(negedge clk);
		rchk(8'h07, 8'h09);
		for (int i = 0; i < 8; i++) begin
			i_host.rd_item(it);
			chk("sample", it, {5'h01, 19'(i)});
		end
		i_host.rd_item(it);
		chk("stamp tag", {19'h00000, it[23:19]}, {19'h00000, 5'h1e});
	endtask

	// data-ready flag alone on the pin, both ways of clearing it
	task automatic t_ready;
		logic [7:0] d;
		i_host.wr(8'h03, 8'h40);
		i_host.rd(8'h00, d);
		ichk(1'b1);
		push(5'h01, 19'h00030);
		ichk(1'b0);
		i_host.rd(8'h08, d);
		ichk(1'b0);
		i_host.wr(8'h0a, 8'h0a);
		i_host.rd(8'h08, d);
		ichk(1'b1);
		push(5'h01, 19'h00031);
		rchk(8'h00, 8'h40);
		ichk(1'b1);
	endtask

	////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// the run needs under a thousand cycles; this leaves ample margin
	initial begin
		#100us;
		err_total++;
		final_report;
	end

	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		t_reset;
		t_format;
		t_full;
		t_afull;
		t_stamp;
		t_ready;
		final_report;
	end
endmodule
